/* rtl/tsptc_pkg.sv */
package tsptc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] TSPTC_ADDR_CTRL = 8'h04;
  localparam logic [7:0] TSPTC_ADDR_STAT = 8'h08;
  localparam int TSPTC_B_FMT_LO  = 0;
  localparam int TSPTC_B_BURST   = 8;
  localparam int TSPTC_B_STATE   = 16;
  localparam int TSPTC_B_FILL    = 22;
  localparam int TSPTC_B_UFL_EN  = 24;
  localparam int TSPTC_B_SYNC_EN = 25;
  localparam int TSPTC_B_FILLED  = 0;
  localparam int TSPTC_B_UFL     = 9;
  localparam int TSPTC_B_SYNC    = 10;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    TSPTC_FMT_188 = 2'b00,
    TSPTC_FMT_204 = 2'b01,
    TSPTC_FMT_PAD = 2'b10,
    TSPTC_FMT_RAW = 2'b11
  } tsptc_fmt_t;

  typedef enum logic [1:0] {
    TSPTC_ST_STOPPED = 2'b00,
    TSPTC_ST_PREFILL = 2'b01,
    TSPTC_ST_RSVD    = 2'b10,
    TSPTC_ST_SENDING = 2'b11
  } tsptc_state_t;

  // ==========================================================
  // Packet layout and timing
  localparam logic [7:0] TSPTC_LEN_188  = 8'd188;
  localparam logic [7:0] TSPTC_LEN_204  = 8'd204;
  localparam logic [7:0] TSPTC_SYNC     = 8'h47;
  localparam logic [7:0] TSPTC_NULL_PID_HI = 8'h1f;
  localparam logic [7:0] TSPTC_NULL_PID_LO = 8'hff;
  localparam logic [7:0] TSPTC_NULL_AFC = 8'h10;
  localparam logic [7:0] TSPTC_STUFF    = 8'hff;
  localparam logic [7:0] TSPTC_PAD      = 8'h00;
  localparam logic [7:0] TSPTC_K285     = 8'hbc;
  localparam int TSPTC_FIFO_W     = 8;
  localparam int TSPTC_FIFO_D     = 8;
  localparam logic [3:0] TSPTC_HIGH_WM   = 4'd8;
  localparam logic [3:0] TSPTC_FREE_MIN  = 4'd4;
  localparam logic [3:0] TSPTC_SLOT_DIV  = 4'd4;
endpackage : tsptc_pkg

/* rtl/tsptc_fifo_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Fill and drain sides of the transmit FIFO
interface tsptc_fifo_if #(parameter int W = 8, parameter int D = 8);
  logic [W-1:0]         wr_data;
  logic                 wr_valid;
  logic                 wr_ready;
  logic [W-1:0]         rd_data;
  logic                 rd_valid;
  logic                 rd_ready;
  logic [$clog2(D):0]   count;
  logic                 clear;
  modport fifo (input wr_data, wr_valid, rd_ready, clear, output wr_ready, rd_data, rd_valid, count);
  modport user (output wr_data, wr_valid, rd_ready, clear, input wr_ready, rd_data, rd_valid, count);
endinterface : tsptc_fifo_if
`default_nettype wire

/* rtl/tsptc_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tsptc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic  clk_sys_i,
  input  wire logic  rst_i,
  tsptc_fifo_if.fifo f
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  wire           push = f.wr_valid && f.wr_ready;
  wire           pop  = f.rd_valid && f.rd_ready;

  // ==========================================================
  // Honest flags: ready drops when full, valid only with data
  assign f.wr_ready = (cnt_reg != D[AW:0]) && !f.clear;
  assign f.rd_valid = (cnt_reg != '0) && !f.clear;
  assign f.rd_data  = mem[rp_reg];
  assign f.count    = cnt_reg;

  // Storage needs no reset
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wp_reg] <= f.wr_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || f.clear) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= push ? wp_reg + 1'b1 : wp_reg;
      rp_reg  <= pop ? rp_reg + 1'b1 : rp_reg;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : tsptc_fifo
`default_nettype wire

/* rtl/tsptc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tsptc_top (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [tsptc_pkg::TSPTC_FIFO_W-1:0] dma_data_i,
  input  wire logic        dma_valid_i,
  output logic             dma_ready_o,
  output logic             dma_req_o,
  output logic      [7:0]  tx_data_o,
  output logic             tx_k_o,
  output logic             tx_strobe_o,
  output logic             irq_o
);
  import tsptc_pkg::*;

  // ==========================================================
  // Output framer states
  typedef enum logic [2:0] {
    TSPTC_OS_START = 3'b001,
    TSPTC_OS_DATA  = 3'b010,
    TSPTC_OS_NULL  = 3'b100
  } tsptc_os_t;

  // ==========================================================
  // Control and status registers
  tsptc_fmt_t   fmt_reg;
  tsptc_state_t state_reg;
  logic         burst_reg;
  logic         fill_reg;
  logic         ufl_en_reg;
  logic         sync_en_reg;
  logic         ufl_reg;
  logic         sync_reg;
  logic [31:0]  rdata_reg;

  // Framer state
  tsptc_os_t    os_reg;
  tsptc_os_t    os_next;
  logic [7:0]   pos_reg;
  logic [7:0]   pos_next;
  logic         gap_reg;
  logic         gap_next;
  logic [3:0]   div_reg;
  logic [7:0]   data_reg;
  logic [7:0]   data_next;
  logic         k_reg;
  logic         k_next;
  logic         strobe_reg;
  logic         pop_c;
  logic         ufl_ev;
  logic         sync_ev;

  tsptc_fifo_if #(.W(TSPTC_FIFO_W), .D(TSPTC_FIFO_D)) fif ();

  tsptc_fifo #(.W(TSPTC_FIFO_W), .D(TSPTC_FIFO_D)) u_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .f         (fif.fifo)
  );

  // ==========================================================
  // Decoding
  wire       wr_ctrl   = reg_wr_i && (reg_addr_i == TSPTC_ADDR_CTRL);
  wire       wr_stat   = reg_wr_i && (reg_addr_i == TSPTC_ADDR_STAT);
  wire       slot      = (div_reg == TSPTC_SLOT_DIV - 4'd1);
  wire       sending   = (state_reg == TSPTC_ST_SENDING);
  wire       prefill   = (state_reg == TSPTC_ST_PREFILL);
  wire       raw_fmt   = (fmt_reg == TSPTC_FMT_RAW);
  wire       fifo_full = (fif.count == TSPTC_HIGH_WM);
  wire [3:0] free_cnt  = 4'(TSPTC_FIFO_D) - fif.count;
  // Source length in FIFO and length on the wire
  wire [7:0] src_len   = (fmt_reg == TSPTC_FMT_204) ? TSPTC_LEN_204 : TSPTC_LEN_188;
  wire [7:0] pkt_len   = (fmt_reg == TSPTC_FMT_188) ? TSPTC_LEN_188 : TSPTC_LEN_204;
  wire       last_byte = (pos_reg == pkt_len - 8'd1);
  // Null packet header, stuffing payload, zero tail beyond 188
  wire [7:0] null_byte = (pos_reg == 8'd1) ? TSPTC_NULL_PID_HI :
                         (pos_reg == 8'd2) ? TSPTC_NULL_PID_LO :
                         (pos_reg == 8'd3) ? TSPTC_NULL_AFC :
                         (pos_reg >= TSPTC_LEN_188) ? TSPTC_PAD : TSPTC_STUFF;

  // DMA requests: never when stopped, until watermark in prefill, on free space in sending
  assign dma_req_o   = (prefill && !fifo_full) ||
                       (sending && (free_cnt >= TSPTC_FREE_MIN));
  assign dma_ready_o = fif.wr_ready && (state_reg != TSPTC_ST_STOPPED);
  assign fif.wr_data  = dma_data_i;
  assign fif.wr_valid = dma_valid_i && (state_reg != TSPTC_ST_STOPPED);
  assign fif.rd_ready = pop_c;
  assign fif.clear    = 1'b0;

  // ==========================================================
  // Framer decision for one output slot
  always_comb begin
    os_next   = os_reg;
    pos_next  = pos_reg;
    gap_next  = gap_reg;
    data_next = TSPTC_K285;
    k_next    = 1'b1;
    pop_c     = 1'b0;
    ufl_ev    = 1'b0;
    sync_ev   = 1'b0;
    if (slot) begin
      if (raw_fmt) begin
        // Every byte popped is sent; null fill is never inserted
        if (sending && fif.rd_valid && !gap_reg) begin
          pop_c     = 1'b1;
          data_next = fif.rd_data;
          k_next    = 1'b0;
          gap_next  = !burst_reg;
        end else begin
          gap_next  = 1'b0;
          ufl_ev    = sending && !fif.rd_valid;
        end
      end else begin
        case (os_reg)
          TSPTC_OS_START: begin
            if (sending && fif.rd_valid) begin
              pop_c = 1'b1;
              if (fif.rd_data == TSPTC_SYNC) begin
                data_next = fif.rd_data;
                k_next    = 1'b0;
                pos_next  = 8'd1;
                gap_next  = !burst_reg;
                os_next   = TSPTC_OS_DATA;
              end else begin
                // Misplaced sync: drop byte and keep hunting
                sync_ev   = 1'b1;
              end
            end else if (fill_reg) begin
              data_next = TSPTC_SYNC;
              k_next    = 1'b0;
              pos_next  = 8'd1;
              os_next   = TSPTC_OS_NULL;
              ufl_ev    = sending;
            end else begin
              ufl_ev    = sending;
            end
          end
          TSPTC_OS_DATA: begin
            if (gap_reg) begin
              gap_next  = 1'b0;
            end else if (pos_reg >= src_len) begin
              data_next = TSPTC_PAD;
              k_next    = 1'b0;
            end else if (sending && fif.rd_valid) begin
              pop_c     = 1'b1;
              data_next = fif.rd_data;
              k_next    = 1'b0;
            end else begin
              ufl_ev    = sending;
            end
            if (!k_next) begin
              gap_next = !burst_reg;
              pos_next = last_byte ? 8'd0 : pos_reg + 8'd1;
              os_next  = last_byte ? TSPTC_OS_START : TSPTC_OS_DATA;
            end
          end
          TSPTC_OS_NULL: begin
            data_next = null_byte;
            k_next    = 1'b0;
            pos_next  = last_byte ? 8'd0 : pos_reg + 8'd1;
            os_next   = last_byte ? TSPTC_OS_START : TSPTC_OS_NULL;
          end
          default: begin
            os_next  = TSPTC_OS_START;
            pos_next = 8'd0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Slot divider: one byte slot every few system cycles
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_reg <= 4'd0;
    end else begin
      div_reg <= slot ? 4'd0 : div_reg + 4'd1;
    end
  end

  // Framer registers; output byte is registered with its strobe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      os_reg     <= TSPTC_OS_START;
      pos_reg    <= 8'd0;
      gap_reg    <= 1'b0;
      data_reg   <= TSPTC_K285;
      k_reg      <= 1'b1;
      strobe_reg <= 1'b0;
    end else begin
      os_reg     <= os_next;
      pos_reg    <= pos_next;
      gap_reg    <= gap_next;
      data_reg   <= slot ? data_next : data_reg;
      k_reg      <= slot ? k_next : k_reg;
      strobe_reg <= slot;
    end
  end

  // ==========================================================
  // Control register; a reserved state value keeps the old state, other fields still load
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fmt_reg     <= TSPTC_FMT_188;
      state_reg   <= TSPTC_ST_STOPPED;
      burst_reg   <= 1'b0;
      fill_reg    <= 1'b0;
      ufl_en_reg  <= 1'b0;
      sync_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      fmt_reg     <= tsptc_fmt_t'(reg_wdata_i[TSPTC_B_FMT_LO +: 2]);
      if (reg_wdata_i[TSPTC_B_STATE +: 2] != TSPTC_ST_RSVD) begin
        state_reg <= tsptc_state_t'(reg_wdata_i[TSPTC_B_STATE +: 2]);
      end
      burst_reg   <= reg_wdata_i[TSPTC_B_BURST];
      fill_reg    <= reg_wdata_i[TSPTC_B_FILL];
      ufl_en_reg  <= reg_wdata_i[TSPTC_B_UFL_EN];
      sync_en_reg <= reg_wdata_i[TSPTC_B_SYNC_EN];
    end
  end

  // Sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ufl_reg  <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      ufl_reg  <= ufl_ev || (ufl_reg && !(wr_stat && reg_wdata_i[TSPTC_B_UFL]));
      sync_reg <= sync_ev || (sync_reg && !(wr_stat && reg_wdata_i[TSPTC_B_SYNC]));
    end
  end

  // Read data; unmapped offsets read as zero
  wire [31:0] ctrl_rd = (32'(fmt_reg) << TSPTC_B_FMT_LO) | (32'(burst_reg) << TSPTC_B_BURST) |
                        (32'(state_reg) << TSPTC_B_STATE) | (32'(fill_reg) << TSPTC_B_FILL) |
                        (32'(ufl_en_reg) << TSPTC_B_UFL_EN) | (32'(sync_en_reg) << TSPTC_B_SYNC_EN);
  wire [31:0] stat_rd = (32'(fifo_full) << TSPTC_B_FILLED) | (32'(ufl_reg) << TSPTC_B_UFL) |
                        (32'(sync_reg) << TSPTC_B_SYNC);
  wire [31:0] rd_mux  = (reg_addr_i == TSPTC_ADDR_CTRL) ? ctrl_rd :
                        (reg_addr_i == TSPTC_ADDR_STAT) ? stat_rd : 32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      rdata_reg <= rd_mux;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = rdata_reg;
  assign tx_data_o   = data_reg;
  assign tx_k_o      = k_reg;
  assign tx_strobe_o = strobe_reg;
  assign irq_o       = (ufl_reg && ufl_en_reg) || (sync_reg && sync_en_reg);
endmodule : tsptc_top
`default_nettype wire

/* verif/tsptc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// =========
// Port checks
module tsptc_checker
  import tsptc_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [7:0]  dma_data_i,
  input wire logic        dma_valid_i,
  input wire logic        dma_ready_o,
  input wire logic        dma_req_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_k_o,
  input wire logic        tx_strobe_o,
  input wire logic        irq_o
);
  logic [1:0] fmt_reg;
  logic [1:0] st_reg;
  logic [1:0] en_reg;
  logic       fill_reg;
  logic       quiet;
  // Control shadow; a reserved state write keeps the old state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {fmt_reg, st_reg, en_reg, fill_reg} <= 7'h00;
    end else if (reg_wr_i && reg_addr_i == TSPTC_ADDR_CTRL) begin
      fmt_reg  <= reg_wdata_i[1:0];
      st_reg   <= (reg_wdata_i[17:16] == TSPTC_ST_RSVD) ? st_reg : reg_wdata_i[17:16];
      en_reg   <= reg_wdata_i[25:24];
      fill_reg <= reg_wdata_i[22];
    end
  end
  // Halted without fill must show only fill characters
  assign quiet = (st_reg != TSPTC_ST_SENDING) && !fill_reg;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_gap; !tx_strobe_o [*3] ##1 tx_strobe_o; endsequence
  property p_slot; tx_strobe_o |=> s_gap; endproperty
  property p_k_data; tx_k_o |-> tx_data_o == TSPTC_K285; endproperty
  property p_quiet; tx_strobe_o && $past(quiet) && $past(quiet, 2) |-> tx_k_o; endproperty
  property p_stop_dma; st_reg == TSPTC_ST_STOPPED |-> !dma_req_o && !dma_ready_o; endproperty
  property p_prefill; st_reg == TSPTC_ST_PREFILL |-> dma_req_o == dma_ready_o; endproperty
  property p_send_req; st_reg == TSPTC_ST_SENDING && dma_req_o |-> dma_ready_o; endproperty
  property p_irq_off; en_reg == 2'h0 |-> !irq_o; endproperty
  property p_ctrl_rd;
    reg_rd_i && reg_addr_i == TSPTC_ADDR_CTRL
      |=> reg_rdata_o[17:16] == $past(st_reg) && reg_rdata_o[1:0] == $past(fmt_reg);
  endproperty
  a_slot: assert property (p_slot) else $error("slot spacing wrong");
  a_k_data: assert property (p_k_data) else $error("fill character wrong");
  a_quiet: assert property (p_quiet) else $error("data while halted");
  a_stop_dma: assert property (p_stop_dma) else $error("dma while stopped");
  a_prefill: assert property (p_prefill) else $error("prefill request wrong");
  a_send_req: assert property (p_send_req) else $error("request with fifo full");
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
endmodule : tsptc_checker
bind tsptc_top tsptc_checker u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .dma_data_i(dma_data_i), .dma_valid_i(dma_valid_i), .dma_ready_o(dma_ready_o), .dma_req_o(dma_req_o),
  .tx_data_o(tx_data_o), .tx_k_o(tx_k_o), .tx_strobe_o(tx_strobe_o), .irq_o(irq_o));
`default_nettype wire

/* verif/tsptc_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
// =========
// Host DMA source
module tsptc_dma_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       dma_ready_o,
  input  wire logic       dma_req_o,
  output logic      [7:0] dma_data_i,
  output logic            dma_valid_i
);
  logic [7:0] q[$];
  logic       taken = 1'b0;
  logic       v;
  int         slow = 0;
  int         gap = 0;
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  // Handshake as seen at the edge, before updates land
  always @(posedge clk_sys_i) taken <= dma_valid_i && dma_ready_o;
  // Offer only on request, hold until taken; idle data toggles so stale bytes never look valid
  initial begin
    dma_valid_i = 1'b0;
    dma_data_i  = 8'h5a;
    forever begin
      @(posedge clk_sys_i);
      #1;
      v = dma_valid_i && !taken;
      if (taken) begin
        void'(q.pop_front());
        gap = slow;
      end
      if (gap > 0) gap--;
      else if (!v && q.size() > 0 && dma_req_o && !rst_i) v = 1'b1;
      dma_valid_i = v;
      dma_data_i  = v ? q[0] : ~dma_data_i;
    end
  end
endmodule : tsptc_dma_model
`default_nettype wire

/* verif/tsptc_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// =========
// Register-driven tests
module tsptc_bench;
  import tsptc_pkg::*;
  logic        clk_sys_i, rst_i, reg_wr_i, reg_rd_i, dma_valid_i;
  logic [7:0]  reg_addr_i, dma_data_i, tx_data_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic        dma_ready_o, dma_req_o, tx_k_o, tx_strobe_o, irq_o;
  logic [7:0]  outq[$];
  logic [7:0]  expq[$];
  int          n_errors, checked;
  tsptc_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dma_data_i(dma_data_i),
    .dma_valid_i(dma_valid_i), .dma_ready_o(dma_ready_o), .dma_req_o(dma_req_o), .tx_data_o(tx_data_o),
    .tx_k_o(tx_k_o), .tx_strobe_o(tx_strobe_o), .irq_o(irq_o));
  tsptc_dma_model dma (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dma_ready_o(dma_ready_o),
    .dma_req_o(dma_req_o), .dma_data_i(dma_data_i), .dma_valid_i(dma_valid_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Collect data bytes from the line, fill characters dropped
  always @(posedge clk_sys_i) if (tx_strobe_o && !tx_k_o) outq.push_back(tx_data_o);
  task chk(input logic [31:0] seen, input logic [31:0] expv);
    checked++;
    if (seen !== expv) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i); #1;
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, 1'b1};
    @(posedge clk_sys_i); #1;
    reg_wr_i = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys_i); #1;
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(posedge clk_sys_i); #1;
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask : rd
  task results();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task wait_out(input int n);
    int i;
    for (i = 0; i < 4000 && outq.size() < n; i++) @(posedge clk_sys_i);
    if (i >= 4000) begin
      n_errors++;
      $display("CHECK FAILED %0t output stalled", $time);
      results();
    end
  endtask : wait_out
  // One packet led by a byte that is not a sync byte, then stop and service the flags
  task run(input logic [1:0] f);
    int n, i;
    n = (f == 2'h1) ? 204 : ((f == 2'h3) ? 8 : 188);
    outq.delete();
    expq.delete();
    dma.slow = (f == 2'h1) ? 3 : 0;
    dma.push(8'h11);
    if (f == 2'h3) expq.push_back(8'h11);
    for (i = 0; i < n; i++) begin
      dma.push(i == 0 ? TSPTC_SYNC : i[7:0]);
      expq.push_back(i == 0 ? TSPTC_SYNC : i[7:0]);
    end
    if (f == 2'h2) repeat (16) expq.push_back(TSPTC_PAD);
    if (f == 2'h0) begin
      wr(TSPTC_ADDR_CTRL, 32'h0001_0100);
      for (i = 0; i < 50 && d[0] !== 1'b1; i++) rd(TSPTC_ADDR_STAT);
      chk(d, 32'h1);
      chk(dma_req_o, 1'b0);
      chk(outq.size(), 0);
    end
    // Raw run also sets null fill, which must add nothing to the output
    wr(TSPTC_ADDR_CTRL, 32'h0003_0000 | (f != 2'h3 ? 32'h100 : 32'h40_0000) | f);
    wait_out(expq.size());
    repeat (40) @(posedge clk_sys_i);
    chk(outq.size(), expq.size());
    if (outq.size() == expq.size()) foreach (expq[j]) chk(outq[j], expq[j]);
    rd(TSPTC_ADDR_STAT);
    chk(d, f == 2'h3 ? 32'h200 : 32'h600);
    wr(TSPTC_ADDR_CTRL, 32'h0300_0000 | f);
    chk(irq_o, 1'b1);
    wr(TSPTC_ADDR_STAT, 32'h200);
    chk(irq_o, f != 2'h3);
    wr(TSPTC_ADDR_STAT, 32'h400);
    chk(irq_o, 1'b0);
    rd(TSPTC_ADDR_CTRL);
    chk(d, 32'h0300_0000 | f);
    $display("test format %0d done", f);
  endtask : run
  // Main sequence
  initial begin
    {n_errors, checked} = 0;
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {3'b100, 8'h00, 32'h0};
    d = 32'h0;
    repeat (8) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    rd(TSPTC_ADDR_CTRL);
    chk(d, 32'h0);
    wr(TSPTC_ADDR_CTRL, 32'h0002_0000);
    rd(TSPTC_ADDR_CTRL);
    chk(d, 32'h0);
    $display("test reset defaults done");
    for (int f = 0; f < 4; f++) run(f[1:0]);
    outq.delete();
    wr(TSPTC_ADDR_CTRL, 32'h0040_0000);
    wait_out(4);
    chk({outq[0], outq[1], outq[2], outq[3]}, {TSPTC_SYNC, TSPTC_NULL_PID_HI, TSPTC_NULL_PID_LO, TSPTC_NULL_AFC});
    $display("test null fill done");
    results();
  end
endmodule : tsptc_bench
`default_nettype wire
